// File: rtl/pbmc_pkg.sv
// constants, state enum and state record of the basic mode control block
package pbmc_pkg;

  // register offsets, byte addresses on the apb bus
  localparam logic [11:0] PBMC_OFF_CTRL = 12'h000;
  localparam logic [11:0] PBMC_OFF_STAT = 12'h004;

  // control register field positions
  localparam int PBMC_B_SRST = 15;
  localparam int PBMC_B_LOOP = 14;
  localparam int PBMC_B_SPD = 13;
  localparam int PBMC_B_ANEG = 12;
  localparam int PBMC_B_PDN = 11;
  localparam int PBMC_B_ISO = 10;
  localparam int PBMC_B_RSTRT = 9;
  localparam int PBMC_B_DPLX = 8;

  // reset values of the control fields (strap fields nominally one)
  localparam logic PBMC_RST_SRST = 1'h0;
  localparam logic PBMC_RST_LOOP = 1'h0;
  localparam logic PBMC_RST_SPD = 1'h1;
  localparam logic PBMC_RST_ANEG = 1'h1;
  localparam logic PBMC_RST_PDN = 1'h0;
  localparam logic PBMC_RST_ISO = 1'h0;
  localparam logic PBMC_RST_RSTRT = 1'h0;
  localparam logic PBMC_RST_DPLX = 1'h1;
  localparam logic PBMC_RST_PIN_N = 1'h1;

  // timing: soft reset length in ns, clock period in ns
  localparam int PBMC_CLK_NS = 4;
  localparam int PBMC_SRST_NS = 1000;
  localparam int PBMC_SRST_CYC = (PBMC_SRST_NS + PBMC_CLK_NS - 1) / PBMC_CLK_NS;
  // cycles spent in strap load, lets the synchronisers settle first
  localparam int PBMC_STRAP_CYC = 3;
  localparam int PBMC_CNT_W = 8;

  typedef enum logic [1:0] {
    PBMC_ST_STRAP,
    PBMC_ST_RUN,
    PBMC_ST_SRST
  } pbmc_phase_t;

  typedef struct packed {
    pbmc_phase_t st;
    logic [PBMC_CNT_W-1:0] cnt;
    logic srst;
    logic loop;
    logic spd;
    logic aneg;
    logic pdn;
    logic iso;
    logic rstrt;
    logic dplx;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic core_rst;
    logic pdn_out;
    logic spd_out;
    logic fd_out;
    logic aneg_en_out;
    logic [3:0] mii_rxd;
    logic mii_rx_dv;
    logic mii_rx_oe;
    logic [3:0] line_txd;
    logic line_tx_en;
  } pbmc_state_t;

endpackage

// File: rtl/pbmc_sync_if.sv
// synchronised pin levels passed from the pin synchroniser to the control block
`timescale 1ns/10ps
interface pbmc_sync_if;
  logic pwdn_n;
  logic strap_spd;
  logic strap_aneg;
  logic strap_dplx;
  modport src (output pwdn_n, output strap_spd, output strap_aneg, output strap_dplx);
  modport dst (input pwdn_n, input strap_spd, input strap_aneg, input strap_dplx);
endinterface

// File: rtl/pbmc_pin_sync.sv
// two-flop synchroniser for the power-down pin and the configuration straps
`timescale 1ns/10ps
module pbmc_pin_sync
  import pbmc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic irq_or_powerdown_pin_n,
  input wire logic strap_speed_100,
  input wire logic strap_aneg_en,
  input wire logic strap_full_duplex,
  pbmc_sync_if.src sync
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } pbmc_sync_t;

  localparam logic [3:0] PBMC_SYNC_RST = {PBMC_RST_PIN_N, PBMC_RST_SPD, PBMC_RST_ANEG,
                                          PBMC_RST_DPLX};

  pbmc_sync_t sync_reg;
  pbmc_sync_t sync_next;

  // first stage feeds only the second stage
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = {irq_or_powerdown_pin_n, strap_speed_100, strap_aneg_en,
                    strap_full_duplex};
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= {PBMC_SYNC_RST, PBMC_SYNC_RST};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync.pwdn_n = sync_reg.s2[3];
  assign sync.strap_spd = sync_reg.s2[2];
  assign sync.strap_aneg = sync_reg.s2[1];
  assign sync.strap_dplx = sync_reg.s2[0];

endmodule // pbmc_pin_sync

// File: rtl/pbmc_ctrl.sv
// basic mode control register (bits 15..8) with apb slave and mii steering
//
// How it works
// R1 - writing reset bit resets, then bit self-clears
// R2 - soft reset end reloads strap values
// R3 - loopback bit sends tx data to rx
// R4 - speed bit forces 100 or 10 rate
// R5 - negotiation enable overrides speed and duplex bits
// R6 - speed and negotiation defaults come from straps
// R7 - power-down bit quiets the port, registers work
// R8 - power-down is bit or low pin; pin sets
// R9 - isolate bit cuts mii data, management stays
// R10 - restart write ignored while negotiation disabled
// R11 - restart reads one until negotiation initiated
// R12 - writing restart zero leaves negotiation running
// R13 - duplex bit forces full or half duplex
// R14 - strap fields load from pins after reset
// R15 - zero writes to self-clearing bits do nothing
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
module pbmc_ctrl
  import pbmc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_or_powerdown_pin_n,
  input wire logic strap_speed_100,
  input wire logic strap_aneg_en,
  input wire logic strap_full_duplex,
  input wire logic aneg_init_ack,
  input wire logic aneg_result_100,
  input wire logic aneg_result_fd,
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_rx_oe,
  output logic [3:0] line_txd,
  output logic line_tx_en,
  output logic phy_core_rst,
  output logic power_down,
  output logic speed_100,
  output logic full_duplex,
  output logic aneg_enable,
  output logic aneg_restart_req
);

  typedef enum logic [1:0] {
    PBMC_SEL_NONE,
    PBMC_SEL_CTRL,
    PBMC_SEL_STAT
  } pbmc_sel_t;

  // word decode shared by the read and the write path
  function automatic pbmc_sel_t pbmc_decode(input logic [11:0] addr);
    pbmc_sel_t sel;
    sel = PBMC_SEL_NONE;
    if (addr == PBMC_OFF_CTRL) begin
      sel = PBMC_SEL_CTRL;
    end else if (addr == PBMC_OFF_STAT) begin
      sel = PBMC_SEL_STAT;
    end
    return sel;
  endfunction

  pbmc_sync_if sync ();

  pbmc_pin_sync u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .irq_or_powerdown_pin_n(irq_or_powerdown_pin_n),
    .strap_speed_100(strap_speed_100),
    .strap_aneg_en(strap_aneg_en),
    .strap_full_duplex(strap_full_duplex),
    .sync(sync)
  );

  localparam logic [PBMC_CNT_W-1:0] PBMC_SRST_LAST = PBMC_CNT_W'(PBMC_SRST_CYC - 1);
  localparam logic [PBMC_CNT_W-1:0] PBMC_STRAP_LAST = PBMC_CNT_W'(PBMC_STRAP_CYC - 1);

  localparam pbmc_state_t PBMC_STATE_RST = '{
    st: PBMC_ST_STRAP,
    cnt: '0,
    srst: PBMC_RST_SRST,
    loop: PBMC_RST_LOOP,
    spd: PBMC_RST_SPD,
    aneg: PBMC_RST_ANEG,
    pdn: PBMC_RST_PDN,
    iso: PBMC_RST_ISO,
    rstrt: PBMC_RST_RSTRT,
    dplx: PBMC_RST_DPLX,
    pready: 1'h0,
    pslverr: 1'h0,
    prdata: 32'h0000_0000,
    core_rst: 1'h1,
    pdn_out: 1'h0,
    spd_out: PBMC_RST_SPD,
    fd_out: PBMC_RST_DPLX,
    aneg_en_out: PBMC_RST_ANEG,
    mii_rxd: 4'h0,
    mii_rx_dv: 1'h0,
    mii_rx_oe: 1'h0,
    line_txd: 4'h0,
    line_tx_en: 1'h0
  };

  pbmc_state_t ctl_reg;
  pbmc_state_t ctl_next;

  pbmc_sel_t sel;
  logic acc_phase;
  logic wr_ctrl;
  logic pdn_now;
  logic [15:0] ctrl_view;
  logic [15:0] stat_view;

  // apb: one wait state, the write lands on the edge that samples pready
  assign sel = pbmc_decode(paddr);
  assign acc_phase = psel && penable;
  assign wr_ctrl = acc_phase && ctl_reg.pready && pwrite && (sel == PBMC_SEL_CTRL);
  // effective power-down: register bit or the pin held low
  assign pdn_now = ctl_reg.pdn || !sync.pwdn_n; // see R8

  // read views; lower control bits read as zero
  assign ctrl_view = {ctl_reg.srst, ctl_reg.loop, ctl_reg.spd, ctl_reg.aneg, ctl_reg.pdn,
                      ctl_reg.iso, ctl_reg.rstrt, ctl_reg.dplx, 8'h00};
  assign stat_view = {9'h000, ctl_reg.st == PBMC_ST_RUN, ctl_reg.core_rst, ctl_reg.rstrt,
                      ctl_reg.pdn_out, ctl_reg.fd_out, ctl_reg.spd_out, sync.pwdn_n};

  // whole next-state computation
  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.pready = 1'h0;
    ctl_next.pslverr = 1'h0;

    // answer one cycle after the access phase opens
    if (acc_phase && !ctl_reg.pready) begin
      ctl_next.pready = 1'h1;
      ctl_next.pslverr = (sel == PBMC_SEL_NONE);
      unique case (sel)
        PBMC_SEL_CTRL: ctl_next.prdata = {16'h0000, ctrl_view};
        PBMC_SEL_STAT: ctl_next.prdata = {16'h0000, stat_view};
        PBMC_SEL_NONE: ctl_next.prdata = 32'h0000_0000;
      endcase
    end

    // negotiation engine took the restart; the bit falls now
    if (ctl_reg.rstrt && aneg_init_ack) begin
      ctl_next.rstrt = 1'h0; // see R11
    end

    unique case (ctl_reg.st)
      PBMC_ST_STRAP: begin
        // hold the core in reset while the straps settle, then latch them
        ctl_next.core_rst = 1'h1;
        ctl_next.cnt = ctl_reg.cnt + PBMC_CNT_W'(1);
        if (ctl_reg.cnt == PBMC_STRAP_LAST) begin
          ctl_next.spd = sync.strap_spd; // see R6, R14, R2
          ctl_next.aneg = sync.strap_aneg; // see R6, R14, R2
          ctl_next.dplx = sync.strap_dplx; // see R14, R2
          ctl_next.srst = 1'h0; // see R1
          ctl_next.core_rst = 1'h0;
          ctl_next.cnt = '0;
          ctl_next.st = PBMC_ST_RUN;
        end
      end
      PBMC_ST_RUN: begin
        if (wr_ctrl && pwdata[PBMC_B_SRST]) begin
          // a reset write discards the rest of the word
          ctl_next.srst = 1'h1; // see R1
          ctl_next.core_rst = 1'h1;
          ctl_next.cnt = '0;
          ctl_next.st = PBMC_ST_SRST;
        end else if (wr_ctrl) begin
          ctl_next.loop = pwdata[PBMC_B_LOOP]; // see R3
          ctl_next.spd = pwdata[PBMC_B_SPD]; // see R4, R6
          ctl_next.aneg = pwdata[PBMC_B_ANEG]; // see R6
          ctl_next.pdn = pwdata[PBMC_B_PDN]; // see R7
          ctl_next.iso = pwdata[PBMC_B_ISO]; // see R9
          ctl_next.dplx = pwdata[PBMC_B_DPLX]; // see R13
          // only a one starts a restart, and only with negotiation on
          if (pwdata[PBMC_B_RSTRT] && pwdata[PBMC_B_ANEG]) begin
            ctl_next.rstrt = 1'h1; // see R10, R15
          end
          // a zero write leaves a pending restart alone, see R12
        end
      end
      PBMC_ST_SRST: begin
        // writes are accepted on the bus but ignored during reset
        ctl_next.cnt = ctl_reg.cnt + PBMC_CNT_W'(1);
        if (ctl_reg.cnt == PBMC_SRST_LAST) begin
          ctl_next.loop = PBMC_RST_LOOP;
          ctl_next.pdn = PBMC_RST_PDN;
          ctl_next.iso = PBMC_RST_ISO;
          ctl_next.rstrt = PBMC_RST_RSTRT;
          ctl_next.cnt = '0;
          ctl_next.st = PBMC_ST_STRAP; // see R2
        end
      end
    endcase

    // pin low forces the bit on, winning over any clear
    if (!sync.pwdn_n) begin
      ctl_next.pdn = 1'h1; // see R8
    end

    // resolved controls for the rest of the phy
    ctl_next.pdn_out = pdn_now; // see R7, R8
    ctl_next.aneg_en_out = ctl_reg.aneg;
    ctl_next.spd_out = ctl_reg.aneg ? aneg_result_100 : ctl_reg.spd; // see R4, R5
    ctl_next.fd_out = ctl_reg.aneg ? aneg_result_fd : ctl_reg.dplx; // see R5, R13

    // mii steering; isolate and power-down win over loopback
    if (ctl_reg.iso || pdn_now || ctl_reg.core_rst) begin
      ctl_next.mii_rx_oe = 1'h0; // see R9, R7
      ctl_next.mii_rxd = 4'h0;
      ctl_next.mii_rx_dv = 1'h0;
      ctl_next.line_txd = 4'h0;
      ctl_next.line_tx_en = 1'h0;
    end else if (ctl_reg.loop) begin
      ctl_next.mii_rx_oe = 1'h1;
      ctl_next.mii_rxd = mii_txd; // see R3
      ctl_next.mii_rx_dv = mii_tx_en; // see R3
      ctl_next.line_txd = 4'h0;
      ctl_next.line_tx_en = 1'h0;
    end else begin
      ctl_next.mii_rx_oe = 1'h1;
      ctl_next.mii_rxd = line_rxd;
      ctl_next.mii_rx_dv = line_rx_dv;
      ctl_next.line_txd = mii_txd;
      ctl_next.line_tx_en = mii_tx_en;
    end
  end

  // the single state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= PBMC_STATE_RST;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // all outputs straight from the state register
  assign prdata = ctl_reg.prdata;
  assign pready = ctl_reg.pready;
  assign pslverr = ctl_reg.pslverr;
  assign mii_rxd = ctl_reg.mii_rxd;
  assign mii_rx_dv = ctl_reg.mii_rx_dv;
  assign mii_rx_oe = ctl_reg.mii_rx_oe;
  assign line_txd = ctl_reg.line_txd;
  assign line_tx_en = ctl_reg.line_tx_en;
  assign phy_core_rst = ctl_reg.core_rst;
  assign power_down = ctl_reg.pdn_out;
  assign speed_100 = ctl_reg.spd_out;
  assign full_duplex = ctl_reg.fd_out;
  assign aneg_enable = ctl_reg.aneg_en_out;
  assign aneg_restart_req = ctl_reg.rstrt;

  // checks; reset bit stays up for the whole reset plus strap load
  localparam int A_SRST_HOLD = PBMC_SRST_CYC + PBMC_STRAP_CYC - 1;

  default clocking a_clk @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  logic wr_srst;
  assign wr_srst = wr_ctrl && pwdata[PBMC_B_SRST] && (ctl_reg.st == PBMC_ST_RUN);

  sequence s_srst_busy;
    ctl_reg.srst ##A_SRST_HOLD ctl_reg.srst;
  endsequence

  sequence s_srst_done;
    !ctl_reg.srst && (ctl_reg.st == PBMC_ST_RUN) && !ctl_reg.core_rst;
  endsequence

  a_srst_self_clear: assert property ( // see R1
    wr_srst |=> s_srst_busy ##1 s_srst_done)
    else $error("soft reset bit did not self-clear on time");

  a_strap_relatch: assert property ( // see R2, R14
    $fell(ctl_reg.srst) |-> (ctl_reg.spd == $past(sync.strap_spd))
      && (ctl_reg.aneg == $past(sync.strap_aneg)) && (ctl_reg.dplx == $past(sync.strap_dplx)))
    else $error("strap values not reloaded after reset");

  a_loop_route: assert property ( // see R3
    (ctl_reg.loop && !ctl_reg.iso && !pdn_now && !ctl_reg.core_rst)
      |=> (mii_rxd == $past(mii_txd)) && (mii_rx_dv == $past(mii_tx_en)) && !line_tx_en)
    else $error("loopback does not route tx data to rx");

  a_force_speed: assert property ( // see R4, R13
    !ctl_reg.aneg |=> (speed_100 == $past(ctl_reg.spd)) && (full_duplex == $past(ctl_reg.dplx)))
    else $error("forced speed or duplex not applied");

  a_aneg_ignore: assert property ( // see R5
    ctl_reg.aneg |=> (speed_100 == $past(aneg_result_100))
      && (full_duplex == $past(aneg_result_fd)))
    else $error("forced bits not ignored under negotiation");

  a_field_write: assert property ( // see R6
    (wr_ctrl && !pwdata[PBMC_B_SRST] && (ctl_reg.st == PBMC_ST_RUN))
      |=> (ctl_reg.spd == $past(pwdata[PBMC_B_SPD]))
      && (ctl_reg.aneg == $past(pwdata[PBMC_B_ANEG])))
    else $error("strap fields not writable");

  a_pdn_or: assert property ( // see R8
    !sync.pwdn_n |=> ctl_reg.pdn && power_down)
    else $error("power-down pin did not set the bit");

  a_pdn_quiet: assert property ( // see R7, R9
    (pdn_now || ctl_reg.iso) |=> !mii_rx_oe && !mii_rx_dv && !line_tx_en)
    else $error("port not quiet while isolated or powered down");

  a_rstrt_ignored: assert property ( // see R10
    (wr_ctrl && pwdata[PBMC_B_RSTRT] && !pwdata[PBMC_B_ANEG] && !ctl_reg.rstrt)
      |=> !ctl_reg.rstrt)
    else $error("restart taken with negotiation disabled");

  a_rstrt_hold: assert property ( // see R11, R12
    (ctl_reg.rstrt && !aneg_init_ack && (ctl_reg.st == PBMC_ST_RUN)) |=> ctl_reg.rstrt)
    else $error("restart bit cleared before negotiation began");

  a_rstrt_clear: assert property ( // see R11
    (ctl_reg.rstrt && aneg_init_ack && !wr_ctrl) |=> !ctl_reg.rstrt)
    else $error("restart bit did not clear on initiation");

  a_zero_inert: assert property ( // see R15
    (wr_ctrl && !pwdata[PBMC_B_SRST] && !pwdata[PBMC_B_RSTRT] && !ctl_reg.rstrt
      && (ctl_reg.st == PBMC_ST_RUN))
      |=> (ctl_reg.st != PBMC_ST_SRST) && !ctl_reg.rstrt)
    else $error("zero write started an operation");

endmodule // pbmc_ctrl

// File: bench/pbmc_far_model.sv
// negotiation engine and phy core stand-in facing the control block
`timescale 1ns/10ps
module pbmc_far_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic quick,
  input wire logic aneg_restart_req,
  output logic aneg_init_ack,
  output logic aneg_result_100,
  output logic aneg_result_fd,
  output logic [3:0] line_rxd,
  output logic line_rx_dv
);
  logic [7:0] wait_cnt;

  // negotiated result is 10 half, so it differs from the forced bits
  assign aneg_result_100 = 1'b0;
  assign aneg_result_fd = 1'b0;

  // ack a restart after a short or long wait; rx data changes every cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= 8'h00;
      aneg_init_ack <= 1'b0;
      line_rxd <= 4'h0;
      line_rx_dv <= 1'b0;
    end else begin
      line_rxd <= line_rxd + 4'h3;
      line_rx_dv <= ~line_rx_dv;
      aneg_init_ack <= 1'b0;
      if (aneg_restart_req && !aneg_init_ack) begin
        wait_cnt <= wait_cnt + 8'h01;
        if (wait_cnt >= (quick ? 8'h01 : 8'h28)) begin
          aneg_init_ack <= 1'b1;
          wait_cnt <= 8'h00;
        end
      end
    end
  end
endmodule // pbmc_far_model

// File: bench/tb.sv
// self-checking testbench of the basic mode control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import pbmc_pkg::*;
  logic mclk, nrst, psel, penable, pwrite, pin_n, s_spd, s_aneg, s_dplx, tx_en, quick;
  logic pready, pslverr, er, ack, r100, rfd, rx_dv, mii_rx_dv, mii_rx_oe, line_tx_en;
  logic core_rst, power_down, speed_100, full_duplex, aneg_enable, restart_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [3:0] txd, mii_rxd, line_rxd, line_txd;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed;

  pbmc_ctrl u_pbmc_ctrl (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_or_powerdown_pin_n(pin_n), .strap_speed_100(s_spd),
    .strap_aneg_en(s_aneg), .strap_full_duplex(s_dplx), .aneg_init_ack(ack),
    .aneg_result_100(r100), .aneg_result_fd(rfd), .mii_txd(txd), .mii_tx_en(tx_en),
    .line_rxd(line_rxd), .line_rx_dv(rx_dv), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv),
    .mii_rx_oe(mii_rx_oe), .line_txd(line_txd), .line_tx_en(line_tx_en),
    .phy_core_rst(core_rst), .power_down(power_down), .speed_100(speed_100),
    .full_duplex(full_duplex), .aneg_enable(aneg_enable), .aneg_restart_req(restart_req));

  pbmc_far_model u_pbmc_far_model (.mclk(mclk), .nrst(nrst), .quick(quick),
    .aneg_restart_req(restart_req), .aneg_init_ack(ack), .aneg_result_100(r100),
    .aneg_result_fd(rfd), .line_rxd(line_rxd), .line_rx_dv(rx_dv));

  // clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // cut a hang short; whole run needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  function automatic logic [31:0] fld(input int b);
    fld = 32'h1 << b;
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge; waits on pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // only the bench timeout ends this wait
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // bounded wait for restart (0) or core reset (1) to fall
  task automatic wait_fall(input logic which, input int lim);
    int k;
    k = 0;
    while ((which ? core_rst : restart_req) !== 1'b0 && k < lim) begin
      @(posedge mclk);
      k++;
    end
    `CHK("fall in time", 1'b1, k < lim)
  endtask

  // one random nibble through the mii steering, loopback or pass-through
  task automatic path(input logic lp);
    logic [3:0] v, el;
    logic edv;
    v = 4'($random(seed));
    txd <= v;
    tx_en <= v[0];
    #1 el = line_rxd;
    edv = rx_dv;
    @(posedge mclk);
    #1 `CHK("mii_rxd", lp ? v : el, mii_rxd)
    `CHK("mii_rx_dv", lp ? v[0] : edv, mii_rx_dv)
    `CHK("line_tx_en", lp ? 1'b0 : v[0], line_tx_en)
    `CHK("line_txd", lp ? 4'h0 : v, line_txd)
    @(posedge mclk);
  endtask

  initial begin
    seed = 32'h7aed;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, txd, tx_en, quick} = '0;
    // pin idle high; straps: 10 half with negotiation on
    {pin_n, s_spd, s_aneg, s_dplx} = 4'hA;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (10) @(posedge mclk);
    // strap values land in the register
    apb(1'b0, PBMC_OFF_CTRL, 32'h0);
    `CHK("ctrl reset", fld(PBMC_B_ANEG), rd)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("unmapped", 1'b1, er)
    // forced speed and duplex, random loopback and isolate
    for (int i = 0; i < 8; i++) begin
      w = ($random(seed) & (fld(PBMC_B_LOOP) | fld(PBMC_B_ISO)));
      w = w | (i[0] ? fld(PBMC_B_SPD) : 32'h0) | (i[1] ? fld(PBMC_B_DPLX) : 32'h0);
      apb(1'b1, PBMC_OFF_CTRL, w);
      apb(1'b0, PBMC_OFF_CTRL, 32'h0);
      `CHK("ctrl rw", w, rd)
      `CHK("speed_100", i[0], speed_100)
      `CHK("full_duplex", i[1], full_duplex)
      `CHK("mii_rx_oe", ~w[PBMC_B_ISO], mii_rx_oe)
      if (w[PBMC_B_ISO]) `CHK("iso rxd", 4'h0, mii_rxd)
      else path(w[PBMC_B_LOOP]);
    end
    // negotiation overrides the forced bits
    apb(1'b1, PBMC_OFF_CTRL, fld(PBMC_B_ANEG) | fld(PBMC_B_SPD) | fld(PBMC_B_DPLX));
    repeat (2) @(posedge mclk);
    `CHK("aneg speed", 1'b0, speed_100)
    `CHK("aneg duplex", 1'b0, full_duplex)
    `CHK("aneg_enable", 1'b1, aneg_enable)
    // restart ignored with negotiation off, then held until acked
    apb(1'b1, PBMC_OFF_CTRL, fld(PBMC_B_RSTRT));
    apb(1'b0, PBMC_OFF_CTRL, 32'h0);
    `CHK("restart off", 32'h0, rd)
    apb(1'b1, PBMC_OFF_CTRL, fld(PBMC_B_ANEG) | fld(PBMC_B_RSTRT));
    apb(1'b0, PBMC_OFF_CTRL, 32'h0);
    `CHK("restart on", fld(PBMC_B_ANEG) | fld(PBMC_B_RSTRT), rd)
    apb(1'b1, PBMC_OFF_CTRL, fld(PBMC_B_ANEG));
    apb(1'b0, PBMC_OFF_CTRL, 32'h0);
    `CHK("restart kept", fld(PBMC_B_ANEG) | fld(PBMC_B_RSTRT), rd)
    wait_fall(1'b0, 100);
    apb(1'b0, PBMC_OFF_CTRL, 32'h0);
    `CHK("restart done", fld(PBMC_B_ANEG), rd)
    quick <= 1'b1;
    apb(1'b1, PBMC_OFF_CTRL, fld(PBMC_B_ANEG) | fld(PBMC_B_RSTRT));
    wait_fall(1'b0, 10);
    `CHK("zero writes", 1'b0, core_rst)
    // power-down by bit and by pin
    apb(1'b1, PBMC_OFF_CTRL, fld(PBMC_B_PDN));
    // output lags the bit by one cycle
    @(posedge mclk);
    `CHK("pdn bit", 1'b1, power_down)
    apb(1'b1, PBMC_OFF_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK("pdn clear", 1'b0, power_down)
    pin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK("pdn pin", 1'b1, power_down)
    pin_n <= 1'b1;
    apb(1'b0, PBMC_OFF_CTRL, 32'h0);
    `CHK("pin sets bit", fld(PBMC_B_PDN), rd)
    apb(1'b1, PBMC_OFF_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK("pdn off", 1'b0, power_down)
    // soft reset with new straps, loopback set beforehand
    {s_spd, s_aneg, s_dplx} <= 3'h5;
    apb(1'b1, PBMC_OFF_CTRL, fld(PBMC_B_LOOP));
    apb(1'b1, PBMC_OFF_CTRL, fld(PBMC_B_SRST));
    `CHK("core rst", 1'b1, core_rst)
    apb(1'b0, PBMC_OFF_CTRL, 32'h0);
    `CHK("srst bit", 1'b1, rd[PBMC_B_SRST])
    wait_fall(1'b1, 400);
    repeat (2) @(posedge mclk);
    apb(1'b0, PBMC_OFF_CTRL, 32'h0);
    `CHK("after srst", fld(PBMC_B_SPD) | fld(PBMC_B_DPLX), rd)
    end_of_test();
  end
endmodule // tb
